// *** fssc_pkg.sv ***
// Constants, register map and types shared by the fan speed controller files.
package fssc_pkg;

	// ==========================================================
	// Clocking and timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_HZ = 81_920;
	localparam int UPD_SLOW_MS = 800;
	localparam int UPD_SLOW_CYC = (CLK_HZ / 1000) * UPD_SLOW_MS;
	localparam int OFF_STEP_US = 10;
	localparam int OFF_STEP_CYC = (CLK_HZ / 1_000_000) * OFF_STEP_US;

	// ==========================================================
	// Widths
	localparam int ACC_W = 27;
	localparam int UPD_W = 27;
	localparam int PER_W = 16;
	localparam int OFF_W = 8;
	localparam int OFF_CNT_W = 18;
	localparam int HP_W = 7;
	localparam int RESP_W = 3;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_CFG1 = 8'h01;
	localparam logic [7:0] ADDR_CFG2 = 8'h02;
	localparam logic [7:0] ADDR_POLES = 8'h03;
	localparam logic [7:0] ADDR_TGT_LO = 8'h2A;
	localparam logic [7:0] ADDR_TGT_HI = 8'h2B;
	localparam logic [7:0] ADDR_RESP = 8'h3C;
	localparam logic [7:0] ADDR_PER_LO = 8'h4A;
	localparam logic [7:0] ADDR_PER_HI = 8'h4B;
	localparam logic [7:0] ADDR_STAT3 = 8'h51;

	// ==========================================================
	// Field positions and reset values
	localparam int CFG1_SEL_BIT = 7;
	localparam int CFG2_BOOST_DIS_BIT = 1;
	localparam int STAT3_ALARM_BIT = 6;
	localparam logic [RESP_W-1:0] RESP_RST = 3'h1;
	localparam logic [7:0] POLES_RST = 8'h04;
	localparam logic [PER_W-1:0] TGT_RST = 16'h0000;
	localparam logic [PER_W-1:0] PER_MAX = 16'hFFFF;
	localparam logic [OFF_W-1:0] OFF_MAX = 8'hFF;

	typedef enum logic [0:0] {
		FSSC_ST_ON = 1'b0,
		FSSC_ST_OFF = 1'b1
	} fssc_drv_st_t;

endpackage : fssc_pkg

// *** fssc_period_meter.sv ***
// Revolution period meter: 81.92 kHz tick and saturating 16-bit period counter.
`timescale 1ns/100ps
`default_nettype none
module fssc_period_meter
	import fssc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic tach_rise_i,
	input wire logic [fssc_pkg::HP_W-1:0] half_poles_i,
	output logic [fssc_pkg::PER_W-1:0] period_o,
	output logic period_done_o
);

	// ==========================================================
	// Tick generator and counter
	// A fractional accumulator gives the exact mean tick rate without a second clock.
	logic [ACC_W-1:0] acc_ff, nxt_acc;
	logic tick_ff, nxt_tick;
	logic [PER_W-1:0] cnt_ff, nxt_cnt;
	logic [PER_W-1:0] per_ff, nxt_per;
	logic [HP_W-1:0] rev_ff, nxt_rev;
	logic done_ff, nxt_done;

	always_comb
	begin
		nxt_tick = 1'b0;
		nxt_acc = acc_ff + ACC_W'(TICK_HZ);
		if (nxt_acc >= ACC_W'(CLK_HZ))
		begin
			nxt_acc = nxt_acc - ACC_W'(CLK_HZ);
			nxt_tick = 1'b1; // [RULE3]
		end
		nxt_cnt = cnt_ff;
		nxt_rev = rev_ff;
		nxt_per = per_ff;
		nxt_done = 1'b0;
		if (tach_rise_i)
		begin
			if (rev_ff + HP_W'(1) >= half_poles_i) // [RULE4]
			begin
				nxt_per = cnt_ff; // [RULE3]
				nxt_done = 1'b1;
				nxt_cnt = '0;
				nxt_rev = '0;
			end
			else
			begin
				nxt_rev = rev_ff + HP_W'(1);
			end
		end
		else if (tick_ff && cnt_ff != PER_MAX)
		begin
			nxt_cnt = cnt_ff + PER_W'(1); // [RULE7]
		end
		if (nxt_cnt == PER_MAX)
		begin
			nxt_per = PER_MAX; // [RULE7]
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			acc_ff <= '0;
			tick_ff <= 1'b0;
			cnt_ff <= '0;
			per_ff <= PER_MAX; // [RULE5]
			rev_ff <= '0;
			done_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			tick_ff <= nxt_tick;
			cnt_ff <= nxt_cnt;
			per_ff <= nxt_per;
			rev_ff <= nxt_rev;
			done_ff <= nxt_done;
		end
	end

	assign period_o = per_ff;
	assign period_done_o = done_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	count_step_a: assert property (tick_ff && !tach_rise_i && cnt_ff != PER_MAX |=> cnt_ff == $past(cnt_ff) + 16'h0001) else $error("period counter missed a tick"); // [RULE3]
	count_sat_a: assert property (cnt_ff == PER_MAX && !tach_rise_i |=> cnt_ff == PER_MAX && per_ff == PER_MAX) else $error("period counter wrapped"); // [RULE7]
	rev_end_a: assert property (tach_rise_i && rev_ff + 7'h01 >= half_poles_i |=> done_ff && per_ff == $past(cnt_ff) && cnt_ff == 16'h0000) else $error("revolution end not published"); // [RULE4]

endmodule : fssc_period_meter
`default_nettype wire

// *** fssc_top.sv ***
// Synchronous fan speed controller: drive sequencer, off-time regulator and registers.
// Operation
// [RULE1] Drive on until a tach transition, then off for the off-time, repeat.
// [RULE2] Too fast lengthens the off-time; too slow shortens it.
// [RULE3] Period counts 81.92 kHz ticks in 16 bits over one revolution.
// [RULE4] Pole count from register; each tach period is two poles.
// [RULE5] Period held as low and high read-only bytes, reset to all ones.
// [RULE6] Low byte read first freezes the high byte until it is read.
// [RULE7] Stalled or very slow fan reads all ones; counter saturates.
// [RULE8] Alarm-speed flag set while over-temperature forces full speed, unless boost disabled.
// [RULE9] Each update compares measured period to target and adjusts off-time.
// [RULE10] Three-bit response code selects 1.25 to 160 updates per second, reset 001.
// [RULE11] Manual mode regulates to the software target.
// [RULE12] Configuration bit 7 clear selects manual, set selects table mode; the bit is only stored, both modes regulate to the target.
// [RULE13] Target is a 16-bit full-rotation period count compared directly.
// [RULE14] Tach synchronised before edge detection; off-time steps by one, bounded.
`timescale 1ns/100ps
`default_nettype none
module fssc_top
	import fssc_pkg::*;
#(
	parameter int UPD_SLOW_CYC_P = fssc_pkg::UPD_SLOW_CYC
)
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic tach_i,
	input wire logic over_temp_limit_signal_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic fan_drive_o
);

	// ==========================================================
	// Elaboration check
	// The fastest rate divides the slowest period by 128, so it must stay above one cycle.
	if (UPD_SLOW_CYC_P < 256 || UPD_SLOW_CYC_P >= (1 << UPD_W))
	begin : g_bad_upd
		$error("UPD_SLOW_CYC_P out of range");
	end

	// ==========================================================
	// Tach synchroniser
	logic tach_s1_ff, tach_s2_ff, tach_s3_ff;
	logic tach_edge, tach_rise;

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			// Reset to the pull-up level so that leaving reset does not fake a tach edge.
			tach_s1_ff <= 1'b1;
			tach_s2_ff <= 1'b1;
			tach_s3_ff <= 1'b1;
		end
		else
		begin
			tach_s1_ff <= tach_i; // [RULE14]
			tach_s2_ff <= tach_s1_ff;
			tach_s3_ff <= tach_s2_ff;
		end
	end

	assign tach_edge = tach_s2_ff ^ tach_s3_ff; // [RULE14]
	assign tach_rise = tach_s2_ff & ~tach_s3_ff;

	// ==========================================================
	// Configuration registers
	logic sel_ff, nxt_sel;
	logic boost_dis_ff, nxt_boost_dis;
	logic [7:0] poles_ff, nxt_poles;
	logic [PER_W-1:0] tgt_ff, nxt_tgt;
	logic [RESP_W-1:0] resp_ff, nxt_resp;

	always_comb
	begin
		nxt_sel = sel_ff;
		nxt_boost_dis = boost_dis_ff;
		nxt_poles = poles_ff;
		nxt_tgt = tgt_ff;
		nxt_resp = resp_ff;
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				ADDR_CFG1: nxt_sel = reg_wdata_i[CFG1_SEL_BIT]; // [RULE12]
				ADDR_CFG2: nxt_boost_dis = reg_wdata_i[CFG2_BOOST_DIS_BIT];
				ADDR_POLES: nxt_poles = reg_wdata_i; // [RULE4]
				ADDR_TGT_LO: nxt_tgt[7:0] = reg_wdata_i; // [RULE13]
				ADDR_TGT_HI: nxt_tgt[15:8] = reg_wdata_i;
				ADDR_RESP: nxt_resp = reg_wdata_i[RESP_W-1:0]; // [RULE10]
				default: nxt_sel = sel_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sel_ff <= 1'b0;
			boost_dis_ff <= 1'b0;
			poles_ff <= POLES_RST;
			tgt_ff <= TGT_RST;
			resp_ff <= RESP_RST; // [RULE10]
		end
		else
		begin
			sel_ff <= nxt_sel;
			boost_dis_ff <= nxt_boost_dis;
			poles_ff <= nxt_poles;
			tgt_ff <= nxt_tgt;
			resp_ff <= nxt_resp;
		end
	end

	// ==========================================================
	// Period measurement
	logic [PER_W-1:0] period;

	fssc_period_meter u_meter (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.tach_rise_i(tach_rise),
		.half_poles_i(poles_ff[HP_W:1]), // [RULE4]
		.period_o(period),
		.period_done_o()
	);

	// ==========================================================
	// Off-time regulator
	// Table mode has no curve here, so both modes regulate to the programmed target.
	logic [UPD_W-1:0] upd_cnt_ff, nxt_upd_cnt;
	logic [OFF_W-1:0] off_time_ff, nxt_off_time;
	logic upd_tick;

	assign upd_tick = (upd_cnt_ff == '0);

	always_comb
	begin
		nxt_off_time = off_time_ff;
		nxt_upd_cnt = upd_cnt_ff - UPD_W'(1);
		if (upd_tick)
		begin
			nxt_upd_cnt = UPD_W'((UPD_SLOW_CYC_P >> resp_ff) - 1); // [RULE10]
			if (period < tgt_ff && off_time_ff != OFF_MAX) // [RULE9] [RULE11]
			begin
				nxt_off_time = off_time_ff + OFF_W'(1); // [RULE2] [RULE14]
			end
			else if (period > tgt_ff && off_time_ff != '0)
			begin
				nxt_off_time = off_time_ff - OFF_W'(1); // [RULE2] [RULE14]
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			upd_cnt_ff <= '0;
			off_time_ff <= '0;
		end
		else
		begin
			upd_cnt_ff <= nxt_upd_cnt;
			off_time_ff <= nxt_off_time;
		end
	end

	// ==========================================================
	// Drive sequencer
	fssc_drv_st_t st_ff, nxt_st;
	logic drive_ff, nxt_drive;
	logic [OFF_CNT_W-1:0] off_cnt_ff, nxt_off_cnt;
	logic alarm_ff, nxt_alarm;
	logic boost;

	assign boost = over_temp_limit_signal_i && !boost_dis_ff; // [RULE8]

	always_comb
	begin
		nxt_st = st_ff;
		nxt_drive = drive_ff;
		nxt_off_cnt = off_cnt_ff;
		nxt_alarm = boost; // [RULE8]
		case (st_ff)
			FSSC_ST_ON:
			begin
				nxt_drive = 1'b1;
				if (tach_edge && !boost && off_time_ff != '0) // [RULE1]
				begin
					nxt_st = FSSC_ST_OFF;
					nxt_drive = 1'b0;
					nxt_off_cnt = OFF_CNT_W'(OFF_CNT_W'(off_time_ff) * OFF_CNT_W'(OFF_STEP_CYC) - OFF_CNT_W'(1));
				end
			end
			FSSC_ST_OFF:
			begin
				if (boost || off_cnt_ff == '0) // [RULE1] [RULE8]
				begin
					nxt_st = FSSC_ST_ON;
					nxt_drive = 1'b1;
				end
				else
				begin
					nxt_off_cnt = off_cnt_ff - OFF_CNT_W'(1);
				end
			end
			default:
			begin
				nxt_st = FSSC_ST_ON;
				nxt_drive = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_ff <= FSSC_ST_ON;
			drive_ff <= 1'b0;
			off_cnt_ff <= '0;
			alarm_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			drive_ff <= nxt_drive;
			off_cnt_ff <= nxt_off_cnt;
			alarm_ff <= nxt_alarm;
		end
	end

	assign fan_drive_o = drive_ff;

	// ==========================================================
	// Register readback
	// The shadow keeps the high byte of the same sample the low byte came from.
	logic [7:0] rdata_ff, nxt_rdata;
	logic [7:0] shadow_ff, nxt_shadow;
	logic frozen_ff, nxt_frozen;

	always_comb
	begin
		nxt_rdata = rdata_ff;
		nxt_shadow = shadow_ff;
		nxt_frozen = frozen_ff;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				ADDR_CFG1: nxt_rdata = {sel_ff, 7'h00};
				ADDR_CFG2: nxt_rdata = {6'h00, boost_dis_ff, 1'b0};
				ADDR_POLES: nxt_rdata = poles_ff;
				ADDR_TGT_LO: nxt_rdata = tgt_ff[7:0];
				ADDR_TGT_HI: nxt_rdata = tgt_ff[15:8];
				ADDR_RESP: nxt_rdata = {5'h00, resp_ff};
				ADDR_PER_LO:
				begin
					nxt_rdata = period[7:0]; // [RULE5]
					nxt_shadow = period[15:8]; // [RULE6]
					nxt_frozen = 1'b1;
				end
				ADDR_PER_HI:
				begin
					nxt_rdata = frozen_ff ? shadow_ff : period[15:8]; // [RULE6]
					nxt_frozen = 1'b0;
				end
				ADDR_STAT3: nxt_rdata = {1'b0, alarm_ff, 6'h00}; // [RULE8]
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rdata_ff <= 8'h00;
			shadow_ff <= 8'hFF;
			frozen_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			shadow_ff <= nxt_shadow;
			frozen_ff <= nxt_frozen;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	drive_hold_a: assert property (st_ff == FSSC_ST_ON && !tach_edge |=> fan_drive_o) else $error("drive dropped without tach edge"); // [RULE1]
	drive_cut_a: assert property (st_ff == FSSC_ST_ON && tach_edge && !boost && off_time_ff != 8'h00 |=> !fan_drive_o ##1 (!fan_drive_o || $past(boost))) else $error("drive not cut after tach edge"); // [RULE1]
	off_grow_a: assert property (upd_tick && period < tgt_ff && off_time_ff != OFF_MAX |=> off_time_ff == $past(off_time_ff) + 8'h01) else $error("off-time not lengthened"); // [RULE2]
	off_shrink_a: assert property (upd_tick && period > tgt_ff && off_time_ff != 8'h00 |=> off_time_ff == $past(off_time_ff) - 8'h01) else $error("off-time not shortened"); // [RULE2]
	off_hold_a: assert property (!upd_tick |=> $stable(off_time_ff)) else $error("off-time moved between updates"); // [RULE9]
	upd_rate_a: assert property (upd_tick |=> upd_cnt_ff == UPD_W'((UPD_SLOW_CYC_P >> $past(resp_ff)) - 1)) else $error("update interval wrong"); // [RULE10]
	hi_freeze_a: assert property (reg_rd_i && reg_addr_i == ADDR_PER_LO ##1 (!reg_rd_i)[*2] ##1 reg_rd_i && reg_addr_i == ADDR_PER_HI |=> reg_rdata_o == $past(shadow_ff)) else $error("high byte not frozen"); // [RULE6]
	alarm_set_a: assert property (boost |=> alarm_ff && fan_drive_o) else $error("alarm speed not entered"); // [RULE8]

	boost_c: cover property (boost ##1 alarm_ff);
	cut_c: cover property (st_ff == FSSC_ST_ON ##1 st_ff == FSSC_ST_OFF ##[1:1000] st_ff == FSSC_ST_ON);
	grow_c: cover property (upd_tick && period < tgt_ff);
	freeze_c: cover property (frozen_ff ##1 !frozen_ff);

endmodule : fssc_top
`default_nettype wire

// *** fssc_fan_model.sv ***
// Behavioural three-wire fan whose tach output is chopped by the drive.
`timescale 1ns/100ps
`default_nettype none
module fssc_fan_model
(
	input wire logic ref_clk_i,
	input wire logic drive_i,
	input wire logic [31:0] half_cyc_i,
	output logic tach_o
);
	// ==========================================================
	// Rotation
	int cnt = 0;
	logic ideal = 1'b0;
	always @(posedge ref_clk_i)
	begin
		if (half_cyc_i == 0)
			cnt <= 0;
		else if (cnt >= half_cyc_i - 1)
		begin
			cnt <= 0;
			ideal <= ~ideal;
		end
		else
			cnt <= cnt + 1;
	end
	// Unpowered or stalled, the open collector lets go and the pull-up wins.
	assign tach_o = (drive_i === 1'b1 && half_cyc_i != 0) ? ideal : 1'b1;
endmodule : fssc_fan_model
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the fan speed controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fssc_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} fssc_row_t;
	// ==========================================================
	// Signals
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic tach_i;
	logic over_temp = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic fan_drive_o;
	int half_cyc = 0;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] v;
	int n;
	// Reads carry expected data, writes carry the value written.
	fssc_row_t rows [25] = '{
		'{0, 8'h3C, 8'h01}, '{0, 8'h4A, 8'hFF}, '{0, 8'h4B, 8'hFF}, '{0, 8'h51, 8'h00},
		'{0, 8'h03, 8'h04}, '{0, 8'h01, 8'h00}, '{0, 8'h02, 8'h00}, '{0, 8'h7F, 8'h00},
		'{1, 8'h4A, 8'h00}, '{0, 8'h4A, 8'hFF}, '{0, 8'h4B, 8'hFF}, '{1, 8'h3C, 8'hFF},
		'{0, 8'h3C, 8'h07}, '{1, 8'h01, 8'hFF}, '{0, 8'h01, 8'h80}, '{1, 8'h02, 8'hFF},
		'{0, 8'h02, 8'h02}, '{1, 8'h2A, 8'hD7}, '{0, 8'h2A, 8'hD7}, '{1, 8'h2B, 8'h03},
		'{0, 8'h2B, 8'h03}, '{1, 8'h01, 8'h00}, '{1, 8'h02, 8'h00}, '{1, 8'h2B, 8'h00},
		'{1, 8'h2A, 8'h00}};
	// ==========================================================
	// Clock, design and fan
	always #5 ref_clk_i = ~ref_clk_i;
	fssc_top #(.UPD_SLOW_CYC_P(1024)) i_dut (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.tach_i(tach_i),
		.over_temp_limit_signal_i(over_temp),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o),
		.fan_drive_o(fan_drive_o)
	);
	fssc_fan_model i_fan (
		.ref_clk_i(ref_clk_i),
		.drive_i(fan_drive_o),
		.half_cyc_i(half_cyc),
		.tach_o(tach_i)
	);
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1 reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge ref_clk_i);
		#1 reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1 reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge ref_clk_i);
		#1 reg_rd_i = 1'b0;
		@(posedge ref_clk_i);
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] r;
		rd(a, r);
		chk(nm, {8'h00, r}, {8'h00, e});
	endtask : rdc
	// Counts edges while the drive holds lvl, giving up after lim.
	task automatic wait_lvl(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (fan_drive_o === lvl && cnt < lim)
		begin
			@(posedge ref_clk_i);
			#1 cnt++;
		end
		chk("wait_limit", 16'(cnt >= lim), 16'h0000);
	endtask : wait_lvl
	task automatic count_low(input int cyc, output int lows);
		lows = 0;
		repeat (cyc)
		begin
			@(posedge ref_clk_i);
			#1 if (fan_drive_o !== 1'b1) lows++;
		end
	endtask : count_low
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// ==========================================================
	// Sequence
	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		#1 arst_n_i = 1'b1;
		@(posedge ref_clk_i);
		#1 chk("drive_on", {15'h0000, fan_drive_o}, 16'h0001);
		for (int i = 0; i < 25; i++)
		begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				rdc(rows[i].a, rows[i].d, "reg_row");
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_RESP, 8'(c));
			rdc(ADDR_RESP, 8'(c), "resp_code");
		end
		// Low byte read while stalled, then the fan starts and a new period lands.
		rdc(ADDR_PER_LO, 8'hFF, "stall_lo");
		half_cyc = 2500;
		count_low(25000, n);
		chk("no_off_below_tgt", 16'(n), 16'h0000);
		rdc(ADDR_PER_HI, 8'hFF, "frozen_hi");
		rdc(ADDR_PER_HI, 8'h00, "live_hi");
		rd(ADDR_PER_LO, v);
		chk("period_4p", 16'(v >= 8 && v <= 9), 16'h0001);
		rdc(ADDR_PER_HI, 8'h00, "period_hi");
		wr(ADDR_POLES, 8'h02);
		count_low(12000, n);
		rd(ADDR_PER_LO, v);
		chk("period_2p", 16'(v >= 4 && v <= 5), 16'h0001);
		rdc(ADDR_PER_HI, 8'h00, "period_hi2");
		// Target slower than the fan makes the off-time grow.
		wr(ADDR_RESP, 8'h00);
		wr(ADDR_TGT_HI, 8'hFF);
		wr(ADDR_TGT_LO, 8'hFF);
		wait_lvl(1'b1, 20000, n);
		chk("drive_fall", {15'h0000, fan_drive_o}, 16'h0000);
		wait_lvl(1'b0, 300000, n);
		chk("off_len", 16'(n % 1000 == 0 && n >= 1000), 16'h0001);
		over_temp = 1'b1;
		count_low(3, n);
		count_low(10000, n);
		chk("boost_high", 16'(n), 16'h0000);
		rdc(ADDR_STAT3, 8'h40, "alarm_set");
		wr(ADDR_CFG2, 8'h02);
		rdc(ADDR_STAT3, 8'h00, "alarm_off");
		wait_lvl(1'b1, 20000, n);
		chk("boost_dis_fall", {15'h0000, fan_drive_o}, 16'h0000);
		over_temp = 1'b0;
		wr(ADDR_CFG2, 8'h00);
		// Target zero winds the off-time down to its floor.
		wr(ADDR_TGT_LO, 8'h00);
		wr(ADDR_TGT_HI, 8'h00);
		wr(ADDR_RESP, 8'h07);
		wait_lvl(1'b0, 300000, n);
		count_low(8000, n);
		chk("off_floor", 16'(n), 16'h0000);
		// Reset in mid-run drops the drive and reloads the period and the rate.
		arst_n_i = 1'b0;
		@(posedge ref_clk_i);
		#1 chk("rst_drive", {15'h0000, fan_drive_o}, 16'h0000);
		repeat (5) @(posedge ref_clk_i);
		#1 arst_n_i = 1'b1;
		rdc(ADDR_PER_LO, 8'hFF, "rst_per_lo");
		rdc(ADDR_PER_HI, 8'hFF, "rst_per_hi");
		rdc(ADDR_RESP, 8'h01, "rst_resp");
		close_out();
	end
	// A hang shows as a mismatch rather than a silent stop.
	initial
	begin
		#990_000;
		errors++;
		close_out();
	end
endmodule : tb
`default_nettype wire
